//--- rtl/host_dma_bus_release_defs.svh
`ifndef HOST_DMA_BUS_RELEASE_DEFS_SVH
`define HOST_DMA_BUS_RELEASE_DEFS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_ADDRX 8'h08
`define REG_LEN 8'h0C
`define REG_STATUS 8'h10
`define REG_MASK 8'h14
`define REG_STATE 8'h18
// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define CTRL_GO_BIT 0
`define CTRL_BURST_BIT 1
`define CTRL_RETRY_LSB 8
`define CTRL_RETRY_MSB 15
`define EV_DONE_BIT 0
`define EV_BERR_BIT 1
`define EV_RLS_BIT 2
`define EV_W 3
`define HALF_W 16
`define RETRY_W 8
// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000
`define RST_RETRY 8'h00
`define RST_EV 3'h0
`define HALF_ONE 16'h0001
`define HALF_MAX 16'hFFFF
`define RETRY_ONE 8'h01
`endif

//--- rtl/host_dma_bus_release_pkg.sv
package host_dma_bus_release_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_REQ, S_TX, S_T1, S_T2, S_T3, S_T4, S_I1, S_I2
  } bus_state_t;
endpackage : host_dma_bus_release_pkg

//--- rtl/host_dma_bus_release.sv
`timescale 1ns/1ps
`include "host_dma_bus_release_defs.svh"
// Operation
// R1: Synchronise release request before acting
// R2: Ignore release request when not owner
// R3: Finish started cycle, then give bus
// R4: No cycle started: release, start none
// R5: Arbiter holds request until ownership drops
// R6: Bus error ends transfer, ignoring ready
// R7: Nonzero retry setting repeats failed cycle
// R8: Zero retry: release, stop system DMA
// R9: Pass bus error to local side halt
// R10: Ignore bus error outside DMA cycles
// R11: Address and length undefined after error
// R12: Cycle-steal inserts extended state every transfer
// R13: Burst: extended state first, on carry
// R14: Transfer acknowledge is never sampled
// R15: Drop hold request after last T4
// R16: Chip select disabled while owning bus
// R17: Float outputs before dropping ownership
module host_dma_bus_release (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  input wire logic host_chip_select_n_i,
  input wire logic bus_release_request_n_i,
  input wire logic bus_error_n_i,
  input wire logic system_ready_n_i,
  input wire logic hold_ack_i,
  output logic hold_request_o,
  output logic bus_owned_n_o,
  output logic [31:0] bus_addr_o,
  output logic bus_addr_oe_o,
  output logic bus_cmd_o,
  output logic bus_cmd_oe_o,
  output logic ext_addr_latch_o,
  output logic local_dma_halt_o,
  output logic host_cs_enable_o,
  output host_dma_bus_release_pkg::bus_state_t bus_state_o
);
  import host_dma_bus_release_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  bus_state_t state_r, state_nxt;
  logic rls_meta_r, rls_sync_r;
  logic go_r, burst_r, halted_r, err_r, first_r, carry_r;
  logic [`RETRY_W-1:0] retry_set_r, retry_left_r;
  logic [`HALF_W-1:0] dma_address_reg, dma_address_extension_reg, dma_length_reg;
  logic [`EV_W-1:0] status_r, mask_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic in_xfer(input bus_state_t s);
    in_xfer = (s == S_TX) || (s == S_T1) || (s == S_T2) || (s == S_T3) || (s == S_T4);
  endfunction : in_xfer

  wire owned_w = in_xfer(state_r) || (state_r == S_I1);
  // Slave access only while the DMA side does not own the bus
  wire access_ok = !host_chip_select_n_i && !owned_w; // see R16
  wire wr_en = reg_wr_i && access_ok;
  wire rd_en = reg_rd_i && access_ok;
  wire wr_ctrl = wr_en && (reg_addr_i == `REG_CTRL);
  wire wr_addr = wr_en && (reg_addr_i == `REG_ADDR);
  wire wr_addrx = wr_en && (reg_addr_i == `REG_ADDRX);
  wire wr_len = wr_en && (reg_addr_i == `REG_LEN);
  wire wr_stat = wr_en && (reg_addr_i == `REG_STATUS);
  wire wr_mask = wr_en && (reg_addr_i == `REG_MASK);
  wire rls_seen = !rls_sync_r;
  wire run_ok = go_r && !halted_r && (dma_length_reg != `RST_HALF);
  // Bus error only counts inside the data states of a DMA cycle
  wire berr_hit = (state_r == S_T2 || state_r == S_T3) && !bus_error_n_i; // see R10
  wire need_tx = !burst_r || first_r || carry_r; // see R12 see R13
  wire retry_go = err_r && (retry_left_r != `RST_RETRY);
  wire abort_go = err_r && (retry_left_r == `RST_RETRY);
  wire last_xfer = (dma_length_reg == `HALF_ONE);
  wire ok_t4 = (state_r == S_T4) && !err_r;
  wire carry_w = ok_t4 && (dma_address_reg == `HALF_MAX);
  wire [`EV_W-1:0] ev_set = {
    (state_r == S_T4) && !err_r && rls_seen && !last_xfer,
    (state_r == S_T4) && abort_go,
    ok_t4 && last_xfer
  };
  wire [31:0] rd_word =
    (reg_addr_i == `REG_CTRL) ? {16'h0000, retry_set_r, 6'h00, burst_r, go_r} :
    (reg_addr_i == `REG_ADDR) ? {16'h0000, dma_address_reg} :
    (reg_addr_i == `REG_ADDRX) ? {16'h0000, dma_address_extension_reg} :
    (reg_addr_i == `REG_LEN) ? {16'h0000, dma_length_reg} :
    (reg_addr_i == `REG_STATUS) ? {29'h0000_0000, status_r} :
    (reg_addr_i == `REG_MASK) ? {29'h0000_0000, mask_r} :
    (reg_addr_i == `REG_STATE) ? {26'h000_0000, halted_r, owned_w, state_r} :
    `RST_WORD;

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  // The transfer acknowledge pin is deliberately not an input here. see R14
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        // A release request alone never moves us: we do not own the bus
        if (run_ok) state_nxt = S_REQ; // see R2
      end
      S_REQ: begin
        // Granted but nothing started: give it straight back
        if (hold_ack_i) state_nxt = rls_seen ? S_I1 : S_TX; // see R4
      end
      S_TX: state_nxt = S_T1;
      S_T1: state_nxt = S_T2;
      S_T2: state_nxt = S_T3;
      S_T3: begin
        if (berr_hit || !system_ready_n_i) state_nxt = S_T4; // see R6
      end
      S_T4: begin
        if (retry_go) state_nxt = need_tx ? S_TX : S_T1; // see R7
        else if (abort_go) state_nxt = S_I1; // see R8
        else if (last_xfer || rls_seen || !burst_r) state_nxt = S_I1; // see R3
        else state_nxt = (!burst_r || carry_w) ? S_TX : S_T1; // see R13
      end
      S_I1: state_nxt = S_I2;
      S_I2: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Two-flop synchroniser on the asynchronous release request
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rls_meta_r <= 1'b1;
      rls_sync_r <= 1'b1;
    end else if (clk_en_i) begin
      rls_meta_r <= bus_release_request_n_i; // see R1
      rls_sync_r <= rls_meta_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      err_r <= 1'b0;
      first_r <= 1'b0;
      carry_r <= 1'b0;
      retry_left_r <= `RST_RETRY;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      if (state_r == S_T3) err_r <= berr_hit;
      if (state_r == S_REQ) first_r <= 1'b1;
      else if (ok_t4) first_r <= 1'b0;
      if (ok_t4) carry_r <= carry_w;
      if (state_r == S_REQ || ok_t4) retry_left_r <= retry_set_r;
      else if (state_r == S_T4 && retry_go) retry_left_r <= retry_left_r - `RETRY_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs, registered from the next state, except bus_addr_o, registered from the address registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_request_o <= 1'b0;
      bus_owned_n_o <= 1'b1;
      bus_addr_oe_o <= 1'b0;
      bus_cmd_oe_o <= 1'b0;
      bus_cmd_o <= 1'b0;
      ext_addr_latch_o <= 1'b0;
      host_cs_enable_o <= 1'b1;
      bus_addr_o <= `RST_WORD;
      bus_state_o <= S_IDLE;
    end else if (clk_en_i) begin
      // Hold falls on the edge that leaves the final T4
      hold_request_o <= (state_nxt == S_REQ) || in_xfer(state_nxt); // see R15
      // Ownership outlives the drivers by one state, so I1 floats first
      bus_owned_n_o <= !(in_xfer(state_nxt) || state_nxt == S_I1); // see R17
      bus_addr_oe_o <= in_xfer(state_nxt);
      bus_cmd_oe_o <= in_xfer(state_nxt) && (state_nxt != S_TX);
      bus_cmd_o <= (state_nxt == S_T2) || (state_nxt == S_T3);
      ext_addr_latch_o <= (state_nxt == S_TX);
      host_cs_enable_o <= !(in_xfer(state_nxt) || state_nxt == S_I1); // see R16
      bus_addr_o <= {dma_address_extension_reg, dma_address_reg};
      bus_state_o <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Software registers and engine updates
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_r <= 1'b0;
      burst_r <= 1'b0;
      retry_set_r <= `RST_RETRY;
      halted_r <= 1'b0;
      local_dma_halt_o <= 1'b0;
      dma_address_reg <= `RST_HALF;
      dma_address_extension_reg <= `RST_HALF;
      dma_length_reg <= `RST_HALF;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        go_r <= reg_wdata_i[`CTRL_GO_BIT];
        burst_r <= reg_wdata_i[`CTRL_BURST_BIT];
        retry_set_r <= reg_wdata_i[`CTRL_RETRY_MSB:`CTRL_RETRY_LSB];
      end
      // A fatal error stops both sides until software rewrites control
      if (state_r == S_T4 && abort_go) begin
        halted_r <= 1'b1; // see R8
        local_dma_halt_o <= 1'b1; // see R9
      end else if (wr_ctrl) begin
        halted_r <= 1'b0;
        local_dma_halt_o <= 1'b0;
      end
      // Address and length are left as they fell after an abort. see R11
      if (wr_addr) dma_address_reg <= reg_wdata_i[`HALF_W-1:0];
      else if (ok_t4) dma_address_reg <= dma_address_reg + `HALF_ONE;
      if (wr_addrx) dma_address_extension_reg <= reg_wdata_i[`HALF_W-1:0];
      else if (carry_w) dma_address_extension_reg <= dma_address_extension_reg + `HALF_ONE;
      if (wr_len) dma_length_reg <= reg_wdata_i[`HALF_W-1:0];
      else if (ok_t4) dma_length_reg <= dma_length_reg - `HALF_ONE;
    end
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= `RST_EV;
      mask_r <= `RST_EV;
      irq_o <= 1'b0;
      reg_rdata_o <= `RST_WORD;
    end else if (clk_en_i) begin
      status_r <= (status_r & ~(wr_stat ? reg_wdata_i[`EV_W-1:0] : `RST_EV)) | ev_set;
      if (wr_mask) mask_r <= reg_wdata_i[`EV_W-1:0];
      irq_o <= |(((status_r & ~(wr_stat ? reg_wdata_i[`EV_W-1:0] : `RST_EV)) | ev_set)
                 & (wr_mask ? reg_wdata_i[`EV_W-1:0] : mask_r));
      reg_rdata_o <= rd_en ? rd_word : `RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ignore_unowned;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_IDLE && !run_ok) |=> (state_r == S_IDLE);
  endproperty
  a_ignore_unowned: assert property (p_ignore_unowned) else $error("left idle without work"); // see R2

  property p_sync_delay;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_REQ && hold_ack_i && rls_sync_r) |=> (state_r == S_TX);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("grant without release not taken"); // see R1

  property p_release_after_cycle;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_T4 && !err_r && rls_seen) |=> (state_r == S_I1) ##1 (state_r == S_I2);
  endproperty
  a_release_after_cycle: assert property (p_release_after_cycle) else $error("release late"); // see R3

  property p_release_no_start;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_REQ && hold_ack_i && rls_seen) |=> (state_r == S_I1 && !bus_addr_oe_o);
  endproperty
  a_release_no_start: assert property (p_release_no_start) else $error("cycle began"); // see R4

  property p_error_ends;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_T3 && !bus_error_n_i && system_ready_n_i) |=> (state_r == S_T4 && err_r);
  endproperty
  a_error_ends: assert property (p_error_ends) else $error("error did not end cycle"); // see R6

  property p_retry;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_T4 && retry_go) |=> (state_r inside {S_TX, S_T1}) && $stable(dma_address_reg);
  endproperty
  a_retry: assert property (p_retry) else $error("failed cycle not repeated"); // see R7

  property p_abort_halts;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_T4 && abort_go) |=> (local_dma_halt_o && halted_r && !hold_request_o)
        ##1 (state_r == S_I2) ##1 (state_r == S_IDLE) ##1 (state_r == S_IDLE);
  endproperty
  a_abort_halts: assert property (p_abort_halts) else $error("abort did not halt"); // see R8

  property p_steal_tx;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_nxt == S_T1 && !burst_r) |-> (state_r == S_TX);
  endproperty
  a_steal_tx: assert property (p_steal_tx) else $error("steal transfer missing TX"); // see R12

  property p_hold_drop;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (state_r == S_T4 && state_nxt == S_I1) |=> (!hold_request_o && !bus_owned_n_o);
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("hold not dropped after T4"); // see R15

  property p_float_first;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $rose(bus_owned_n_o) |-> ($past(bus_addr_oe_o) == 1'b0) && !bus_cmd_oe_o;
  endproperty
  a_float_first: assert property (p_float_first) else $error("ownership dropped while driving"); // see R17

  property p_cs_off;
    @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      !bus_owned_n_o |-> !host_cs_enable_o ##1 (reg_rdata_o == `RST_WORD);
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("chip select live while owning"); // see R16

  c_burst_run: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == S_T4 && burst_r) ##1 (state_r == S_T1));
  c_retry: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == S_T4 && retry_go));
  c_release: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == S_T4 && !err_r && rls_seen && !last_xfer));
  c_carry: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) carry_w && burst_r);
endmodule : host_dma_bus_release

//--- testbench/host_bus_arbiter_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// Arbiter and host CPU side of the system bus
// --------------------------------------------------------------
module host_bus_arbiter_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hold_request_i,
  input wire logic bus_owned_n_i,
  input wire logic bus_cmd_i,
  input wire logic rls_i,
  input wire logic err_arm_i,
  input wire logic idle_err_i,
  input wire logic [3:0] wait_i,
  output logic hold_ack_o,
  output logic bus_release_request_n_o,
  output logic bus_error_n_o,
  output logic system_ready_n_o
);
  logic [3:0] wait_r;
  logic err_r;
  logic err_done_r;
  // Slow ready: the stretch of wait states is set by the bench
  assign system_ready_n_o = !(bus_cmd_i && wait_r >= wait_i);
  assign bus_error_n_o = !(err_r || idle_err_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ack_o <= 1'h0;
      bus_release_request_n_o <= 1'h1;
      wait_r <= 4'h0;
      err_r <= 1'h0;
      err_done_r <= 1'h0;
    end else begin
      hold_ack_o <= hold_request_i;
      wait_r <= bus_cmd_i ? wait_r + 4'h1 : 4'h0;
      // One error pulse per arming, only inside a command phase
      err_r <= err_arm_i && bus_cmd_i && !err_done_r && !err_r;
      err_done_r <= err_arm_i && (err_done_r || err_r);
      if (rls_i) begin
        bus_release_request_n_o <= 1'h0;
      end else if (bus_owned_n_i) begin
        bus_release_request_n_o <= 1'h1;
      end
    end
  end
endmodule : host_bus_arbiter_model

//--- testbench/host_dma_bus_release_bench.sv
`timescale 1ns/1ps
`include "host_dma_bus_release_defs.svh"
module host_dma_bus_release_bench;
  import host_dma_bus_release_pkg::*;
  logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, cs_n, hold_ack, rls_n, err_n, rdy_n;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, addr_o;
  logic irq_o, hold_rq, owned_n, aoe, cmd, cmd_oe, xl, halt, cs_en, rls, arm, ierr;
  logic [3:0] wt;
  bus_state_t st;
  int miscompares, n_tests, n_tx, n_t1;
  host_dma_bus_release dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'h1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .host_chip_select_n_i(cs_n), .bus_release_request_n_i(rls_n),
    .bus_error_n_i(err_n), .system_ready_n_i(rdy_n), .hold_ack_i(hold_ack),
    .hold_request_o(hold_rq), .bus_owned_n_o(owned_n), .bus_addr_o(addr_o),
    .bus_addr_oe_o(aoe), .bus_cmd_o(cmd), .bus_cmd_oe_o(cmd_oe), .ext_addr_latch_o(xl),
    .local_dma_halt_o(halt), .host_cs_enable_o(cs_en), .bus_state_o(st));
  host_bus_arbiter_model arb_u (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .hold_request_i(hold_rq), .bus_owned_n_i(owned_n), .bus_cmd_i(cmd), .rls_i(rls),
    .err_arm_i(arm), .idle_err_i(ierr), .wait_i(wt), .hold_ack_o(hold_ack),
    .bus_release_request_n_o(rls_n), .bus_error_n_o(err_n), .system_ready_n_o(rdy_n));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    #1 check(reg_rdata_o, exp);
  endtask : rd
  // Cycle-steal passes through idle for one cycle between transfers,
  // so only a run of idle samples means the engine has finished
  task automatic wait_idle;
    int quiet;
    quiet = 0;
    for (int i = 0; i < 400 && quiet < 4; i++) begin
      @(posedge sys_clk_i);
      quiet = (st === S_IDLE) ? quiet + 1 : 0;
    end
    check(quiet, 4);
  endtask : wait_idle
  // Go is cleared first so that no transfer starts on stale settings
  task automatic start(input logic [15:0] len, input logic [7:0] retry, input logic burst);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_LEN, {16'h0, len});
    n_tx = 0;
    n_t1 = 0;
    wr(`REG_CTRL, {16'h0, retry, 6'h0, burst, 1'h1});
  endtask : start
  // --------------------------------------------------------------
  // Monitors, clock and watchdog
  // --------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (st === S_TX) n_tx++;
    if (st === S_T1) n_t1++;
    if (st === S_TX) check({xl, aoe, cmd_oe}, 3'h6);
    if (st === S_I1) check({hold_rq, aoe, cmd_oe, owned_n}, 4'h0);
  end
  initial begin
    sys_clk_i = 1'h0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #200us;
    miscompares++;
    complete_run();
  end
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, cs_n, rls, arm, ierr} = 7'h0;
    reg_addr_i = 8'h0;
    reg_wdata_i = 32'h0;
    wt = 4'h0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    rd(`REG_STATE, 32'h0);
    rd(8'h1C, 32'h0);
    ierr <= 1'h1;
    rls <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    {ierr, rls} <= 2'h0;
    rd(`REG_STATUS, 32'h0);
    $display("idle inputs done");
    wr(`REG_ADDR, 32'hFFFF);
    wr(`REG_ADDRX, 32'h0);
    wr(`REG_MASK, 32'h1);
    start(16'h2, 8'h1, 1'h1);
    wait_idle();
    check(n_tx, 2);
    check(addr_o, 32'h0001_0001);
    check(irq_o, 1'h1);
    wr(`REG_MASK, 32'h0);
    @(posedge sys_clk_i);
    #1 check(irq_o, 1'h0);
    wr(`REG_STATUS, 32'h1);
    wr(`REG_ADDR, 32'h10);
    wt = 4'h3;
    start(16'h3, 8'h1, 1'h1);
    wait_idle();
    check({n_tx, n_t1}, {32'h1, 32'h3});
    start(16'h2, 8'h1, 1'h0);
    wait_idle();
    check({n_tx, n_t1}, {32'h2, 32'h2});
    $display("burst and cycle-steal done");
    wr(`REG_STATUS, 32'h7);
    wt = 4'h8;
    arm <= 1'h1;
    start(16'h1, 8'h1, 1'h0);
    wait_idle();
    check({n_tx, n_t1}, {32'h2, 32'h2});
    check(halt, 1'h0);
    rd(`REG_STATUS, 32'h1);
    // The model re-arms only after it has seen arm low at an edge
    arm <= 1'h0;
    @(posedge sys_clk_i);
    arm <= 1'h1;
    wr(`REG_STATUS, 32'h7);
    start(16'h2, 8'h0, 1'h1);
    wait_idle();
    check({n_t1, halt, hold_rq}, {32'h1, 2'h2});
    rd(`REG_STATUS, 32'h2);
    rd(`REG_STATE, 32'h20);
    arm <= 1'h0;
    wr(`REG_CTRL, 32'h0);
    @(posedge sys_clk_i);
    #1 check(halt, 1'h0);
    $display("bus error done");
    wt = 4'h6;
    wr(`REG_STATUS, 32'h7);
    start(16'h4, 8'h1, 1'h1);
    for (int i = 0; i < 50 && owned_n !== 1'h0; i++) @(posedge sys_clk_i);
    #1 check(cs_en, 1'h0);
    rd(`REG_STATE, 32'h0);
    rls <= 1'h1;
    @(posedge sys_clk_i);
    rls <= 1'h0;
    for (int i = 0; i < 50 && st !== S_I1; i++) @(posedge sys_clk_i);
    check(n_t1, 1);
    // Go stays set, so the engine asks again and finishes the length
    wait_idle();
    check({n_tx, n_t1}, {32'h2, 32'h4});
    rd(`REG_STATUS, 32'h5);
    $display("release done");
    // Release held from idle: every grant is handed back untouched
    rls <= 1'h1;
    start(16'h1, 8'h1, 1'h1);
    repeat (30) @(posedge sys_clk_i);
    check(n_tx, 0);
    rst_n_i <= 1'h0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    rls <= 1'h0;
    rd(`REG_STATE, 32'h0);
    $display("grant return and reset done");
    complete_run();
  end
endmodule : host_dma_bus_release_bench
